// ### inc/dbg_pkg.sv
// constants, states and bus carriers of the dead-band generator
package dbg_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int DBG_CNT_W = 8;
  localparam int DBG_SRC_N = 16;
  localparam int DBG_GOUT_N = 4;
  localparam int DBG_ADDR_W = 8;
  localparam int DBG_DATA_W = 32;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] DBG_OFS_CTRL = 8'h00;
  localparam logic [7:0] DBG_OFS_PERIOD = 8'h04;
  localparam logic [7:0] DBG_OFS_COUNT = 8'h08;
  localparam logic [7:0] DBG_OFS_SPARE = 8'h0C;
  localparam logic [7:0] DBG_OFS_INSEL = 8'h10;
  localparam logic [7:0] DBG_OFS_OUTSEL = 8'h14;
  localparam logic [7:0] DBG_OFS_STAT = 8'h18;

  // ----------------------------------------
  // reset values and field positions
  // ----------------------------------------
  localparam logic [7:0] DBG_RST_CTRL = 8'h00;
  localparam logic [7:0] DBG_RST_PERIOD = 8'h00;
  localparam logic [7:0] DBG_RST_COUNT = 8'h00;
  localparam logic [7:0] DBG_RST_INSEL = 8'h00;
  localparam logic [7:0] DBG_RST_OUTSEL = 8'h00;
  localparam int DBG_CTRL_EN_BIT = 0;
  localparam int DBG_INSEL_CLK_LSB = 0;
  localparam int DBG_INSEL_KILL_LSB = 4;
  localparam int DBG_OUTSEL_F0_LSB = 0;
  localparam int DBG_OUTSEL_F0_EN = 2;
  localparam int DBG_OUTSEL_F1_LSB = 4;
  localparam int DBG_OUTSEL_F1_EN = 6;
  localparam logic [1:0] DBG_RESP_OKAY = 2'h0;
  localparam logic [1:0] DBG_RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // sequencer states, gray along the edge cycle
  // ----------------------------------------
  typedef enum logic [2:0] {
    DBG_S_WAIT = 3'h0,
    DBG_S_DEAD_R = 3'h1,
    DBG_S_ON = 3'h3,
    DBG_S_DEAD_F = 3'h7,
    DBG_S_OFF = 3'h5
  } dbg_state_t;

  // ----------------------------------------
  // axi4-lite carriers
  // ----------------------------------------
  typedef struct packed {
    logic [DBG_ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [DBG_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [DBG_ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } dbg_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [DBG_DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } dbg_axi_rsp_t;

endpackage

// ### tb/dbg_deadband_test.sv
// self-checking testbench of the dead-band generator
`timescale 1ns/1ps
module dbg_deadband_test;
  import dbg_pkg::*;
  logic ref_clk;
  logic nrst;
  dbg_axi_req_t req;
  dbg_axi_rsp_t rsp;
  logic wave_in;
  logic [15:0] clk_src_in;
  logic [15:0] kill_src_in = 16'h0000;
  logic in_phase_out, inverted_phase_out, next_blk_clk_out, block_irq;
  logic [3:0] global_out;
  logic run, kill, en, wave_p, tick_p, in_p, inv_p;
  logic hold = 1'b1;
  logic [15:0] hi_len, lo_len;
  logic [3:0] csel, ksel;
  logic [7:0] period;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [33:0] rexp;
  logic [1:0] bexp;
  logic [31:0] seed;
  logic [31:0] rnd = 32'h84A0;
  int errors, num_checks, ticks, stab;
  logic [7:0] p_tab[3] = '{8'h00, 8'h03, 8'hFF};
  logic [3:0] c_tab[3] = '{4'h0, 4'h1, 4'h0};
  logic [3:0] k_tab[3] = '{4'h3, 4'h5, 4'hF};

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  dbg_deadband uut (.ref_clk(ref_clk), .nrst(nrst), .axi_req(req), .axi_rsp(rsp), .wave_in(wave_in),
    .clk_src_in(clk_src_in), .kill_src_in(kill_src_in), .in_phase_out(in_phase_out),
    .inverted_phase_out(inverted_phase_out), .next_blk_clk_out(next_blk_clk_out), .block_irq(block_irq),
    .global_out(global_out));
  dbg_wave_src src (.ref_clk(ref_clk), .nrst(nrst), .run(run), .high_len(hi_len), .low_len(lo_len),
    .wave_out(wave_in), .clk_src_out(clk_src_in));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic miss(input logic ok);
    num_checks++;
    if (!ok)
      errors++;
    return !ok;
  endfunction

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // write holds each channel until its own ready, then waits the response
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bq.push_back(er);
    @(posedge ref_clk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
    end
    while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    rq.push_back({er, ed});
    @(posedge ref_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
    end
    while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
  endtask

  // ----------------------------------------
  // kill lines: random noise on unselected lines
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    rnd = lfsr(rnd);
    kill_src_in <= (rnd[15:0] & ~(16'h0001 << ksel)) | (16'(kill) << ksel);
  end

  // ----------------------------------------
  // watchers
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    if (rsp.rvalid === 1'b1 && req.rready === 1'b1)
    begin
      rexp = rq.size() > 0 ? rq.pop_front() : '1;
      if (miss({rsp.rresp, rsp.rdata} === rexp)) $display("[FAIL] %0t read %h want %h", $time, rsp.rdata, rexp);
    end
    if (rsp.bvalid === 1'b1 && req.bready === 1'b1)
    begin
      bexp = bq.size() > 0 ? bq.pop_front() : 2'h3;
      if (miss(rsp.bresp === bexp)) $display("[FAIL] %0t write response %h", $time, rsp.bresp);
    end
  end

  always @(posedge ref_clk)
  begin
    if (nrst === 1'b1)
    begin
      if (miss((in_phase_out & inverted_phase_out) === 1'b0)) $display("[FAIL] %0t outputs overlap", $time);
      if (miss(next_blk_clk_out === in_phase_out)) $display("[FAIL] %0t next block clock", $time);
      if (miss(block_irq === (in_phase_out & ~in_p))) $display("[FAIL] %0t irq pulse", $time);
      if (hold && miss({in_phase_out, inverted_phase_out, block_irq} === 3'b000))
        $display("[FAIL] %0t output while held low", $time);
      if (((in_phase_out & ~in_p) | (inverted_phase_out & ~inv_p)) && miss(ticks == int'(period) + 1))
        $display("[FAIL] %0t dead time %0d ticks", $time, ticks);
      if (stab > 2 && miss(global_out === {1'b0, inverted_phase_out, in_phase_out, 1'b0}))
        $display("[FAIL] %0t global bus %h", $time, global_out);
    end
    stab = (in_phase_out === in_p && inverted_phase_out === inv_p) ? stab + 1 : 0;
    if (kill_src_in[ksel] || !en || !nrst)
      hold = 1'b1;
    else if (wave_in !== wave_p)
      hold = 1'b0;
    ticks = (wave_in !== wave_p) ? 0 : ticks + int'(clk_src_in[csel] & ~tick_p);
    wave_p = wave_in;
    tick_p = clk_src_in[csel];
    in_p = in_phase_out;
    inv_p = inverted_phase_out;
  end

  initial
  begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    $display("[FAIL] %0t run did not finish", $time);
    test_done;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    int tp;
    int hl;
    int ll;
    nrst = 1'b0;
    req = '0;
    run = 1'b0;
    kill = 1'b0;
    en = 1'b0;
    csel = 4'h0;
    ksel = 4'h0;
    period = 8'h00;
    hi_len = 16'h0014;
    lo_len = 16'h0014;
    seed = 32'h84A0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++)
      rd(8'(i * 4), 32'h0000_0000, DBG_RESP_OKAY);
    rd(8'h1C, 32'h0000_0000, DBG_RESP_SLVERR);
    wr(8'h20, 32'h0000_00FF, DBG_RESP_SLVERR);
    seed = lfsr(seed);
    wr(DBG_OFS_SPARE, seed, DBG_RESP_OKAY);
    rd(DBG_OFS_SPARE, 32'h0000_0000, DBG_RESP_OKAY);
    wr(DBG_OFS_CTRL, 32'hFFFF_FFFE, DBG_RESP_OKAY);
    rd(DBG_OFS_CTRL, 32'h0000_0000, DBG_RESP_OKAY);
    wr(DBG_OFS_OUTSEL, 32'h0000_0065, DBG_RESP_OKAY);
    rd(DBG_OFS_OUTSEL, 32'h0000_0065, DBG_RESP_OKAY);
    for (int k = 0; k < 3; k++)
    begin
      period <= p_tab[k];
      csel <= c_tab[k];
      ksel <= k_tab[k];
      wr(DBG_OFS_PERIOD, {24'h0, p_tab[k]}, DBG_RESP_OKAY);
      rd(DBG_OFS_COUNT, {24'h0, p_tab[k]}, DBG_RESP_OKAY);
      wr(DBG_OFS_INSEL, {24'h0, k_tab[k], c_tab[k]}, DBG_RESP_OKAY);
      rd(DBG_OFS_INSEL, {24'h0, k_tab[k], c_tab[k]}, DBG_RESP_OKAY);
      // widths stay above dead time plus the worst tick phase
      tp = 2 << c_tab[k];
      seed = lfsr(seed);
      hl = (int'(p_tab[k]) + 2) * tp + 4 + int'(seed[2:0]);
      ll = (int'(p_tab[k]) + 2) * tp + 4 + int'(seed[5:3]);
      hi_len <= 16'(hl);
      lo_len <= 16'(ll);
      wr(DBG_OFS_CTRL, 32'h0000_0001, DBG_RESP_OKAY);
      en <= 1'b1;
      run <= 1'b1;
      repeat (4 * (hl + ll)) @(posedge ref_clk);
      // kill in mid-run, then normal restart
      kill <= 1'b1;
      repeat (6) @(posedge ref_clk);
      kill <= 1'b0;
      repeat (3 * (hl + ll)) @(posedge ref_clk);
      wr(DBG_OFS_CTRL, 32'h0000_0000, DBG_RESP_OKAY);
      en <= 1'b0;
      repeat (hl) @(posedge ref_clk);
      run <= 1'b0;
    end
    test_done;
  end
endmodule // dbg_deadband_test

// ### tb/dbg_wave_src.sv
// model of the preceding block: pwm waveform and candidate block clocks
`timescale 1ns/1ps
module dbg_wave_src (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic [15:0] high_len,
  input wire logic [15:0] low_len,
  output logic wave_out,
  output logic [15:0] clk_src_out
);
  logic [15:0] len_q;
  logic [7:0] div_q;
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      wave_out <= 1'b0;
      len_q <= 16'h0000;
    end
    else if (!run)
      len_q <= 16'h0000;
    else if (len_q == 16'h0000)
    begin
      wave_out <= !wave_out;
      len_q <= wave_out ? low_len : high_len;
    end
    else
      len_q <= len_q - 16'h0001;
  // free-running ticks: line k toggles every 2^(k mod 8) cycles
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;
  assign clk_src_out = {div_q, div_q};
endmodule // dbg_wave_src

// ### verilog/dbg_deadband.sv
// dead-band generator with axi4-lite register slave
`timescale 1ns/1ps

// Notes on behaviour
// - two outputs, in phase and inverted, same frequency, never both high
// - 8-bit down counter times the dead interval; both outputs low during it
// - rising input edge drops inverted output, counter runs down from loaded value
// - counter at zero after rising edge raises in-phase output
// - falling edge drops in-phase output; inverted rises after the same dead time
// - counter fixed at 8 bits, at most 256 ticks of dead time
// - period write while disabled also loads the counter
// - every input edge while enabled and not killed reloads the counter from the period register
// - third data register has no function here
// - control register holds one enable bit
// - waveform input is always the preceding block's primary output
// - output high times equal input high or low time less dead time
// - selected block clock decrements the counter, one step per clock
// - kill input high forces both outputs low
// - clock and kill sources picked by the input select register
// - both outputs routable to the global output bus by output select
// - following block sees only the in-phase output as its clock
// - block interrupt on each rising edge of the in-phase output
// - dead time is block clock period times one plus period value
// - input select: clock source in low nibble, kill source in high nibble
module dbg_deadband (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire dbg_pkg::dbg_axi_req_t axi_req,
  output dbg_pkg::dbg_axi_rsp_t axi_rsp,
  input wire logic wave_in,
  input wire logic [dbg_pkg::DBG_SRC_N-1:0] clk_src_in,
  input wire logic [dbg_pkg::DBG_SRC_N-1:0] kill_src_in,
  output logic in_phase_out,
  output logic inverted_phase_out,
  output logic next_blk_clk_out,
  output logic block_irq,
  output logic [dbg_pkg::DBG_GOUT_N-1:0] global_out
);
  import dbg_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic dbg_pick(input logic [DBG_SRC_N-1:0] vec, input logic [3:0] sel);
    dbg_pick = vec[sel];
  endfunction

  function automatic logic [DBG_GOUT_N-1:0] dbg_line(input logic [1:0] sel, input logic en, input logic sig);
    logic [DBG_GOUT_N-1:0] m;
    m = '0;
    m[sel] = en & sig;
    dbg_line = m;
  endfunction

  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] period_q;
  logic [7:0] insel_q;
  logic [7:0] outsel_q;
  logic [DBG_CNT_W-1:0] count_q;
  logic [DBG_CNT_W-1:0] count_d;
  dbg_state_t state_q;
  dbg_state_t state_d;
  logic wave_q;
  logic src_clk_q;
  logic aw_have_q;
  logic w_have_q;
  logic [DBG_ADDR_W-1:0] awaddr_q;
  logic [DBG_DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic awready_q;
  logic wready_q;
  logic [1:0] bresp_q;
  logic bvalid_q;
  logic arready_q;
  logic [DBG_DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;
  logic rvalid_q;
  logic [DBG_DATA_W-1:0] rdata_d;
  logic rd_ok_d;
  logic wr_ok;
  logic do_wr;
  logic period_wr;
  logic en;
  logic kill;
  logic run;
  logic src_clk;
  logic tick;
  logic rise;
  logic fall;

  // separate flops so every response bit has exactly one driving process
  assign axi_rsp = {awready_q, wready_q, bresp_q, bvalid_q, arready_q, rdata_q, rresp_q, rvalid_q};
  assign en = ctrl_q[DBG_CTRL_EN_BIT];

  // ----------------------------------------
  // input selection and edge detection
  // ----------------------------------------
  // source multiplexers
  assign src_clk = dbg_pick(clk_src_in, insel_q[DBG_INSEL_CLK_LSB +: 4]);
  assign kill = dbg_pick(kill_src_in, insel_q[DBG_INSEL_KILL_LSB +: 4]);
  assign tick = src_clk & ~src_clk_q;
  assign rise = wave_in & ~wave_q;
  assign fall = ~wave_in & wave_q;
  assign run = en & ~kill;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wave_q <= 1'b0;
      src_clk_q <= 1'b0;
    end
    else
    begin
      wave_q <= wave_in;
      src_clk_q <= src_clk;
    end
  end

  // ----------------------------------------
  // dead-time sequencer
  // ----------------------------------------
  // a pulse shorter than the dead time restarts the count, so its output never rises
  always_comb
  begin
    state_d = state_q;
    count_d = count_q;
    if (!run)
      state_d = DBG_S_WAIT;
    else if (rise)
    begin
      state_d = DBG_S_DEAD_R;
      count_d = period_q;
    end
    else if (fall)
    begin
      state_d = DBG_S_DEAD_F;
      count_d = period_q;
    end
    else
    begin
      unique case (state_q)
        DBG_S_WAIT, DBG_S_ON, DBG_S_OFF:
          state_d = state_q;
        DBG_S_DEAD_R:
          if (tick)
          begin
            if (count_q == '0)
              state_d = DBG_S_ON;
            else
              count_d = count_q - 1'b1;
          end
        DBG_S_DEAD_F:
          if (tick)
          begin
            if (count_q == '0)
              state_d = DBG_S_OFF;
            else
              count_d = count_q - 1'b1;
          end
        default:
          state_d = DBG_S_WAIT;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      state_q <= DBG_S_WAIT;
    else
      state_q <= state_d;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      count_q <= DBG_RST_COUNT;
    else if (period_wr && !en)
      count_q <= wdata_q[DBG_CNT_W-1:0];
    else
      count_q <= count_d;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // outputs decoded from one state
  // high only after the dead interval
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      in_phase_out <= 1'b0;
      inverted_phase_out <= 1'b0;
      next_blk_clk_out <= 1'b0;
      block_irq <= 1'b0;
    end
    else
    begin
      in_phase_out <= (state_d == DBG_S_ON);
      inverted_phase_out <= (state_d == DBG_S_OFF);
      // chained clock is the in-phase output
      next_blk_clk_out <= (state_d == DBG_S_ON);
      block_irq <= (state_d == DBG_S_ON) && (state_q != DBG_S_ON);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      global_out <= '0;
    else
      global_out <= dbg_line(outsel_q[DBG_OUTSEL_F0_LSB +: 2], outsel_q[DBG_OUTSEL_F0_EN], state_d == DBG_S_ON)
        | dbg_line(outsel_q[DBG_OUTSEL_F1_LSB +: 2], outsel_q[DBG_OUTSEL_F1_EN], state_d == DBG_S_OFF);
  end

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  assign do_wr = aw_have_q & w_have_q & ~bvalid_q;
  assign period_wr = do_wr && (awaddr_q == DBG_OFS_PERIOD) && wstrb_q[0];
  // spare data register accepts and drops writes
  assign wr_ok = (awaddr_q == DBG_OFS_CTRL) || (awaddr_q == DBG_OFS_PERIOD) || (awaddr_q == DBG_OFS_COUNT)
    || (awaddr_q == DBG_OFS_SPARE) || (awaddr_q == DBG_OFS_INSEL) || (awaddr_q == DBG_OFS_OUTSEL)
    || (awaddr_q == DBG_OFS_STAT);

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
      awready_q <= 1'b1;
    end
    else if (axi_req.awvalid && awready_q)
    begin
      aw_have_q <= 1'b1;
      awaddr_q <= axi_req.awaddr;
      awready_q <= 1'b0;
    end
    else if (do_wr)
      aw_have_q <= 1'b0;
    else if (bvalid_q && axi_req.bready)
      awready_q <= 1'b1;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      w_have_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
      wready_q <= 1'b1;
    end
    else if (axi_req.wvalid && wready_q)
    begin
      w_have_q <= 1'b1;
      wdata_q <= axi_req.wdata;
      wstrb_q <= axi_req.wstrb;
      wready_q <= 1'b0;
    end
    else if (do_wr)
      w_have_q <= 1'b0;
    else if (bvalid_q && axi_req.bready)
      wready_q <= 1'b1;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= DBG_RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? DBG_RESP_OKAY : DBG_RESP_SLVERR;
    end
    else if (axi_req.bready)
      bvalid_q <= 1'b0;
  end

  // only byte lane 0 carries register bits
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q <= DBG_RST_CTRL;
      period_q <= DBG_RST_PERIOD;
      insel_q <= DBG_RST_INSEL;
      outsel_q <= DBG_RST_OUTSEL;
    end
    else if (do_wr && wstrb_q[0])
    begin
      if (awaddr_q == DBG_OFS_CTRL)
        ctrl_q <= {7'h00, wdata_q[DBG_CTRL_EN_BIT]};
      if (awaddr_q == DBG_OFS_PERIOD)
        period_q <= wdata_q[7:0];
      if (awaddr_q == DBG_OFS_INSEL)
        insel_q <= wdata_q[7:0];
      if (awaddr_q == DBG_OFS_OUTSEL)
        outsel_q <= wdata_q[7:0] & 8'h77;
    end
  end

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  always_comb
  begin
    rdata_d = '0;
    rd_ok_d = 1'b1;
    unique case (axi_req.araddr)
      DBG_OFS_CTRL: rdata_d[7:0] = ctrl_q;
      DBG_OFS_PERIOD: rdata_d[7:0] = period_q;
      DBG_OFS_COUNT: rdata_d[DBG_CNT_W-1:0] = count_q;
      DBG_OFS_SPARE: rdata_d = '0;
      DBG_OFS_INSEL: rdata_d[7:0] = insel_q;
      DBG_OFS_OUTSEL: rdata_d[7:0] = outsel_q;
      DBG_OFS_STAT: rdata_d[7:0] = {1'b0, state_q, wave_q, kill, inverted_phase_out, in_phase_out};
      default: rd_ok_d = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= DBG_RESP_OKAY;
    end
    else if (axi_req.arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rdata_d;
      rresp_q <= rd_ok_d ? DBG_RESP_OKAY : DBG_RESP_SLVERR;
    end
    else if (rvalid_q && axi_req.rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking dbg_cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // helper: ticks spent in a rising dead interval and the value loaded for it
  logic [8:0] dead_ticks_q;
  logic [7:0] dead_load_q;
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dead_ticks_q <= '0;
      dead_load_q <= '0;
    end
    else if (run && rise)
    begin
      dead_ticks_q <= '0;
      dead_load_q <= period_q;
    end
    else if (state_q == DBG_S_DEAD_R && tick)
      dead_ticks_q <= dead_ticks_q + 9'h001;
  end

  property p_no_overlap;
    !(in_phase_out && inverted_phase_out);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both outputs high");

  property p_dead_low;
    (state_q == DBG_S_DEAD_R || state_q == DBG_S_DEAD_F) |-> !in_phase_out && !inverted_phase_out;
  endproperty
  a_dead_low: assert property (p_dead_low) else $error("output high in dead interval");

  property p_rise_load;
    run && rise |=> !inverted_phase_out && count_q == $past(period_q);
  endproperty
  a_rise_load: assert property (p_rise_load) else $error("rising edge did not reload");

  property p_zero_on;
    run && !rise && !fall && state_q == DBG_S_DEAD_R && tick && count_q == '0 |=> in_phase_out && block_irq;
  endproperty
  a_zero_on: assert property (p_zero_on) else $error("in-phase did not rise at zero");

  property p_fall_off;
    fall |=> !in_phase_out;
  endproperty
  a_fall_off: assert property (p_fall_off) else $error("in-phase stayed high after fall");

  property p_dis_load;
    period_wr && !en |=> count_q == $past(wdata_q[7:0]);
  endproperty
  a_dis_load: assert property (p_dis_load) else $error("disabled period write not loaded");

  property p_kill;
    kill |=> !in_phase_out && !inverted_phase_out && !block_irq;
  endproperty
  a_kill: assert property (p_kill) else $error("kill did not force outputs low");

  property p_irq;
    block_irq == $rose(in_phase_out);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not tied to in-phase rise");

  property p_disabled;
    !en && !period_wr |=> $stable(count_q) && !in_phase_out && !inverted_phase_out;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled block moved");

  property p_dead_len;
    state_q == DBG_S_DEAD_R && state_d == DBG_S_ON |-> dead_ticks_q == {1'b0, dead_load_q};
  endproperty
  a_dead_len: assert property (p_dead_len) else $error("dead interval length wrong");

  property p_chain;
    next_blk_clk_out == in_phase_out;
  endproperty
  a_chain: assert property (p_chain) else $error("chained clock differs from in-phase");

  c_on: cover property (state_q == DBG_S_DEAD_R ##[1:600] state_q == DBG_S_ON);
  c_off: cover property (state_q == DBG_S_DEAD_F ##[1:600] inverted_phase_out);
  c_kill: cover property (in_phase_out ##1 kill);
  c_dis_load: cover property (period_wr && !en);

endmodule // dbg_deadband
